// >>> bench/csr_master_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "csr_map.svh"

// far-side master: issues release requests one at a time
module csr_master_model
	import csr_pkg::*;
(
	input  wire logic     aclk,
	output var  logic     req_valid,
	input  wire logic     req_ready,
	output var  csr_req_t req,
	input  wire logic     rsp_valid,
	output var  logic     rsp_ready,
	input  wire csr_rsp_t rsp
);
	initial begin
		req_valid = 1'b0;
		rsp_ready = 1'b0;
		req       = '0;
	end

	// well-formed request on the unconnected port
	function automatic csr_req_t mk(input logic [7:0] ch);
		csr_req_t q;
		q.rr       = `CSR_RR_REQ;
		q.service  = `CSR_SVC_RELEASE;
		q.unconn   = 1'b1;
		q.class_id = `CSR_CLASS_ID;
		q.inst_id  = `CSR_INST_ID;
		q.choice   = ch;
		return q;
	endfunction : mk

	task automatic send(input csr_req_t r, output csr_rsp_t o);
		req       <= r;
		req_valid <= 1'b1;
		rsp_ready <= 1'b1;
		do @(posedge aclk); while (!req_ready);
		req_valid <= 1'b0;
		// released body shows the inverse so a stale latch is not masked
		req       <= csr_req_t'(~r);
		do @(posedge aclk); while (!rsp_valid);
		o = rsp;
		rsp_ready <= 1'b0;
		@(posedge aclk);
	endtask : send
endmodule : csr_master_model

`default_nettype wire

// >>> bench/tb_conn_set_release_server.sv
`timescale 1ns/1ps
`default_nettype none
`include "csr_map.svh"

module tb_conn_set_release_server
	import csr_pkg::*;
;
	logic        aclk;
	logic        aresetn = 1'b0;
	logic [3:0]  s_axi_awaddr = 4'h0;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'h1;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_wready;
	logic [1:0]  s_axi_bresp;
	logic        s_axi_bvalid;
	logic        s_axi_bready = 1'b0;
	logic [4:0]  s_axi_araddr = 5'h00;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0]  s_axi_rresp;
	logic        s_axi_rvalid;
	logic        s_axi_rready = 1'b0;
	logic        req_valid;
	logic        req_ready;
	csr_req_t    req;
	logic        rsp_valid;
	logic        rsp_ready;
	csr_rsp_t    rsp;
	logic [7:0]  alloc_choice;
	logic        set_allocated;
	int          miscompares = 0;
	int          n_tests = 0;
	logic [31:0] rd;
	logic [1:0]  rr;

	csr_release_server dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .req_valid(req_valid), .req_ready(req_ready),
		.req(req), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp),
		.alloc_choice(alloc_choice), .set_allocated(set_allocated));

	csr_master_model mdl (.aclk(aclk), .req_valid(req_valid), .req_ready(req_ready),
		.req(req), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp));

	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic axw(input logic [3:0] a, input logic [31:0] d);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		chk({30'h0, s_axi_bresp}, 32'h0);
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask : axw

	task automatic axr(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : axr

	// one request, then the whole response is compared
	task automatic rel(input logic [7:0] svc, input logic [7:0] cls, input logic [7:0] ins,
			input logic [7:0] ch, input logic [7:0] eg, input logic [7:0] ea);
		csr_req_t q;
		csr_rsp_t o;
		q          = mdl.mk(ch);
		q.service  = svc;
		q.class_id = cls;
		q.inst_id  = ins;
		mdl.send(q, o);
		chk({o.rr, o.service}, {1'b1, svc});
		chk({o.err, o.gen, o.add}, {eg != 8'h00, eg, ea});
	endtask : rel

	task automatic wrap_up;
		if (miscompares == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : wrap_up

	// whole sequence needs well under 2000 cycles
	initial begin
		repeat (20000) @(posedge aclk);
		miscompares++;
		wrap_up();
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		axr(5'h00, rd, rr);
		chk(rd, 32'h1);
		axw(4'h0, 32'h0);
		rel(8'h4c, 8'h03, 8'h01, 8'h01, 8'h08, 8'hff);
		axw(4'h0, 32'h1);
		rel(8'h0e, 8'h03, 8'h01, 8'h01, 8'h08, 8'h03);
		// an allocate request is not foreign to the port, so no missing-manager code
		rel(8'h4b, 8'h03, 8'h01, 8'h01, 8'h08, 8'hff);
		axw(4'h0, 32'h3);
		rel(8'h0e, 8'h03, 8'h01, 8'h01, 8'h08, 8'hff);
		rel(8'h4c, 8'h04, 8'h01, 8'h01, 8'h16, 8'hff);
		rel(8'h4c, 8'h03, 8'h02, 8'h01, 8'h16, 8'hff);
		axw(4'h4, 32'h37);
		axw(4'h8, 32'h76);
		axw(4'hc, 32'h0313);
		rel(8'h4c, 8'h03, 8'h01, 8'h08, 8'h09, 8'h02);
		rel(8'h4c, 8'h03, 8'h01, 8'h80, 8'h09, 8'h02);
		rel(8'h4c, 8'h03, 8'h01, 8'h48, 8'h09, 8'h02);
		rel(8'h4c, 8'h03, 8'h01, 8'h00, 8'h09, 8'h02);
		rel(8'h4c, 8'h03, 8'h01, 8'h40, 8'h02, 8'h02);
		rel(8'h4c, 8'h03, 8'h01, 8'h44, 8'h02, 8'h02);
		rel(8'h4c, 8'h03, 8'h01, 8'h04, 8'h0b, 8'hff);
		rel(8'h4c, 8'h03, 8'h01, 8'h01, 8'h0c, 8'hff);
		rel(8'h4c, 8'h03, 8'h01, 8'h11, 8'h0c, 8'hff);
		axr(5'h0c, rd, rr);
		chk(rd, 32'h0313);
		chk({set_allocated, alloc_choice}, 9'h113);
		rel(8'h4c, 8'h03, 8'h01, 8'h02, 8'h00, 8'hff);
		axr(5'h0c, rd, rr);
		chk(rd, 32'h0111);
		chk({set_allocated, alloc_choice}, 9'h111);
		// bit 4 still exists but nothing stays established afterwards
		axw(4'h8, 32'h77);
		rel(8'h4c, 8'h03, 8'h01, 8'h01, 8'h00, 8'hff);
		axr(5'h10, rd, rr);
		chk(rd, 32'h0);
		chk({set_allocated, alloc_choice}, 9'h000);
		// a write without the byte-0 strobe must leave the support mask alone
		s_axi_wstrb <= 4'h0;
		axw(4'h4, 32'h0);
		s_axi_wstrb <= 4'h1;
		rel(8'h4c, 8'h03, 8'h01, 8'h10, 8'h0b, 8'hff);
		axr(5'h14, rd, rr);
		chk(rd, 32'h00ff0b00);
		axr(5'h18, rd, rr);
		chk(rd, 32'h0);
		chk({30'h0, rr}, 32'h2);
		wrap_up();
	end
endmodule : tb_conn_set_release_server

`default_nettype wire

// >>> verilog/csr_map.svh
`ifndef CSR_MAP_SVH
`define CSR_MAP_SVH

// request framing
`define CSR_SVC_RELEASE   8'h4c
`define CSR_SVC_ALLOCATE  8'h4b
`define CSR_CLASS_ID      8'h03
`define CSR_INST_ID       8'h01
`define CSR_RR_REQ        1'b0
`define CSR_RR_RSP        1'b1

// release choice byte
`define CSR_BIT_EXPLICIT  0
`define CSR_BIT_POLLED    1
`define CSR_BIT_STROBED   2
`define CSR_BIT_COS       4
`define CSR_BIT_CYCLIC    5
`define CSR_BIT_ACKSUP    6
`define CSR_CHOICE_RSVD   8'h88
`define CSR_CHOICE_CONN   8'h77
`define CSR_CHOICE_NONE   8'h00

// general and additional error codes
`define CSR_GEN_OK        8'h00
`define CSR_GEN_RESOURCE  8'h02
`define CSR_GEN_NOSVC     8'h08
`define CSR_GEN_BADVAL    8'h09
`define CSR_GEN_STATE     8'h0b
`define CSR_GEN_NOSTOP    8'h0c
`define CSR_GEN_NOOBJ     8'h16
`define CSR_ADD_NONE      8'hff
`define CSR_ADD_CONFLICT  8'h01
`define CSR_ADD_CHOICE    8'h02
`define CSR_ADD_NOUCMM    8'h03
`define CSR_ADD_NORES     8'h04

// register byte offsets
`define CSR_OFF_CTRL      4'h0
`define CSR_OFF_SUPPORT   4'h4
`define CSR_OFF_STOPOK    4'h8
`define CSR_OFF_EXIST     4'hc
`define CSR_OFF_ESTAB     4'h0
`define CSR_OFF_STATUS    4'h4
`define CSR_PAGE_LO       1'b0
`define CSR_PAGE_HI       1'b1

// reset values
`define CSR_RST_CTRL      2'h1
`define CSR_RST_MASK      8'h00

// axi responses
`define CSR_RESP_OKAY     2'h0
`define CSR_RESP_SLVERR   2'h2

`endif

// >>> verilog/csr_pkg.sv
package csr_pkg;

	typedef struct packed {
		logic       rr;
		logic [7:0] service;
		logic       unconn;
		logic [7:0] class_id;
		logic [7:0] inst_id;
		logic [7:0] choice;
	} csr_req_t;

	typedef struct packed {
		logic       rr;
		logic [7:0] service;
		logic       err;
		logic [7:0] gen;
		logic [7:0] add;
	} csr_rsp_t;

	typedef enum logic [1:0] {
		CSR_IDLE,
		CSR_EVAL,
		CSR_RESP
	} csr_state_t;

endpackage : csr_pkg

// >>> verilog/csr_release_server.sv
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "csr_map.svh"

// Overview of operation
// - choice byte: bits 0,1,2,4,5,6 select explicit, polled, strobed, cos, cyclic, acksup
// - a one bit releases that connection, a zero leaves it alone
// - reserved bits 3 and 7 must be zero and are checked on receipt
// - an all-zero choice byte answers error 09 with additional 02
// - a release request has rr flag 0 and service 4c
// - on the unconnected port the 8-bit class id must be 3
// - on the unconnected port the 8-bit instance id must be 1
// - the choice byte follows the instance id in the request body
// - success answers rr flag 1 with service 4c
// - all or nothing: on any error nothing is released
// - a node without the connection set answers error 08
// - an unsupported selected connection answers error 02 with additional 02
// - a selected connection in non-existent state answers error 0b
// - if stopping is not permitted, answer error 0c
// - valid release frees resources; empty set is marked unallocated
// - the sender is never compared with the current master
// - with nothing established afterwards, the whole set returns to non-existent
// - without message manager, a non allocate/release unconnected message answers additional 03
// - additional 01 means allocation conflict, 04 means resource unavailable
module csr_release_server
	import csr_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [4:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        req_valid,
	output var  logic        req_ready,
	input  wire csr_req_t    req,
	output var  logic        rsp_valid,
	input  wire logic        rsp_ready,
	output var  csr_rsp_t    rsp,
	output var  logic [7:0]  alloc_choice,
	output var  logic        set_allocated
);

	////////////////////////////////////////////////////////////////////////
	// registers

	csr_state_t state;
	csr_req_t   req_q;
	logic [1:0] ctrl;
	logic [7:0] support;
	logic [7:0] stop_ok;
	logic [7:0] exist;
	logic [7:0] estab;
	logic [7:0] last_gen;
	logic [7:0] last_add;
	logic [3:0] aw_q;
	logic       aw_have;
	logic       w_have;
	logic [31:0] w_q;

	////////////////////////////////////////////////////////////////////////
	// request evaluation

	wire [7:0] sel      = req_q.choice;
	wire       has_set  = ctrl[0];
	wire       has_unconnected_message_manager = ctrl[1];
	wire       is_rel   = req_q.rr == `CSR_RR_REQ && req_q.service == `CSR_SVC_RELEASE;
	wire       e_noset  = !has_set;
	wire       e_svc    = !is_rel;
	wire       e_obj    = req_q.unconn && (req_q.class_id != `CSR_CLASS_ID
	                      || req_q.inst_id != `CSR_INST_ID);
	wire       e_rsvd   = |(sel & `CSR_CHOICE_RSVD);
	wire       e_zero   = sel == `CSR_CHOICE_NONE;
	wire       e_unsup  = |(sel & ~support);
	wire       e_nonex  = |(sel & ~exist);
	wire       e_stop   = |(sel & ~stop_ok);
	// a request from any node is served; no sender id is even carried here
	wire       any_err  = e_noset | e_svc | e_obj | e_rsvd | e_zero
	                      | e_unsup | e_nonex | e_stop;

	// first failing check decides the answer, in this fixed order
	wire [7:0] err_gen  = e_noset ? `CSR_GEN_NOSVC :
	                      e_svc   ? `CSR_GEN_NOSVC :
	                      e_obj   ? `CSR_GEN_NOOBJ :
	                      e_rsvd  ? `CSR_GEN_BADVAL :
	                      e_zero  ? `CSR_GEN_BADVAL :
	                      e_unsup ? `CSR_GEN_RESOURCE :
	                      e_nonex ? `CSR_GEN_STATE :
	                      e_stop  ? `CSR_GEN_NOSTOP : `CSR_GEN_OK;
	// 01 and 04 belong to allocation, which this block never answers
	// allocate belongs on this port too, so it never earns the missing-manager code
	wire       svc_unconnected_message_manager = e_svc && req_q.unconn && !has_unconnected_message_manager
	                      && req_q.service != `CSR_SVC_ALLOCATE;
	wire [7:0] err_add  = e_noset ? `CSR_ADD_NONE :
	                      svc_unconnected_message_manager ? `CSR_ADD_NOUCMM :
	                      e_svc   ? `CSR_ADD_NONE :
	                      e_obj   ? `CSR_ADD_NONE :
	                      (e_rsvd | e_zero | e_unsup) ? `CSR_ADD_CHOICE :
	                      `CSR_ADD_NONE;

	// release: clear selected connections, collapse set when nothing established
	wire [7:0] rel_est  = estab & ~sel;
	wire       collapse = rel_est == `CSR_CHOICE_NONE;
	wire [7:0] rel_ex   = collapse ? `CSR_CHOICE_NONE : (exist & ~sel);
	wire       commit   = state == CSR_EVAL && !any_err;

	wire [7:0] next_gen = any_err ? err_gen : `CSR_GEN_OK;
	wire [7:0] next_add = any_err ? err_add : `CSR_ADD_NONE;
	wire       take_req = req_valid && req_ready;
	wire       rsp_done = rsp_valid && rsp_ready;

	////////////////////////////////////////////////////////////////////////
	// sequencer

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state     <= CSR_IDLE;
			req_q     <= '0;
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp       <= '0;
		end else begin
			case (state)
				CSR_IDLE: begin
					req_ready <= !take_req;
					if (take_req) begin
						req_q <= req;
						state <= CSR_EVAL;
					end
				end
				CSR_EVAL: begin
					rsp.rr      <= `CSR_RR_RSP;
					rsp.service <= req_q.service;
					rsp.err     <= any_err;
					rsp.gen     <= next_gen;
					rsp.add     <= next_add;
					rsp_valid   <= 1'b1;
					state       <= CSR_RESP;
				end
				CSR_RESP: begin
					if (rsp_done) begin
						rsp_valid <= 1'b0;
						req_ready <= 1'b1;
						state     <= CSR_IDLE;
					end
				end
				default: begin
					state     <= CSR_IDLE;
					req_ready <= 1'b0;
					rsp_valid <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// axi4-lite slave; addresses use bit 4 as page, bits 3:0 as byte offset

	wire aw_ok     = s_axi_awvalid && s_axi_awready;
	wire w_ok      = s_axi_wvalid && s_axi_wready;
	wire aw_now    = aw_have || aw_ok;
	wire w_now     = w_have || w_ok;
	wire [3:0] wa  = aw_have ? aw_q : s_axi_awaddr;
	wire [31:0] wd = w_have ? w_q : s_axi_wdata;
	wire do_wr     = aw_now && w_now && !s_axi_bvalid;
	wire wr_byte0  = do_wr && s_axi_wstrb[0] | (do_wr && w_have);
	// writes hit only the low page; the high page is read-only state
	wire wr_ctrl   = wr_byte0 && wa == `CSR_OFF_CTRL;
	wire wr_sup    = wr_byte0 && wa == `CSR_OFF_SUPPORT;
	wire wr_stop   = wr_byte0 && wa == `CSR_OFF_STOPOK;
	wire wr_exist  = wr_byte0 && wa == `CSR_OFF_EXIST;
	logic strb_q;
	wire strb0     = w_have ? strb_q : s_axi_wstrb[0];
	wire wr_en     = do_wr && strb0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `CSR_RESP_OKAY;
			aw_have       <= 1'b0;
			w_have        <= 1'b0;
			aw_q          <= '0;
			w_q           <= '0;
			strb_q        <= 1'b0;
		end else begin
			s_axi_awready <= !aw_now && !s_axi_bvalid;
			s_axi_wready  <= !w_now && !s_axi_bvalid;
			if (aw_ok) begin
				aw_q <= s_axi_awaddr;
			end
			if (w_ok) begin
				w_q    <= s_axi_wdata;
				strb_q <= s_axi_wstrb[0];
			end
			aw_have <= aw_now && !do_wr;
			w_have  <= w_now && !do_wr;
			if (do_wr) begin
				s_axi_bvalid  <= 1'b1;
				s_axi_bresp   <= `CSR_RESP_OKAY;
				s_axi_awready <= 1'b0;
				s_axi_wready  <= 1'b0;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// configuration and connection state

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl          <= `CSR_RST_CTRL;
			support       <= `CSR_RST_MASK;
			stop_ok       <= `CSR_RST_MASK;
			exist         <= `CSR_RST_MASK;
			estab         <= `CSR_RST_MASK;
			set_allocated <= 1'b0;
			last_gen      <= `CSR_GEN_OK;
			last_add      <= `CSR_ADD_NONE;
		end else begin
			if (wr_en && wr_ctrl) begin
				ctrl <= wd[1:0];
			end
			if (wr_en && wr_sup) begin
				support <= wd[7:0] & `CSR_CHOICE_CONN;
			end
			if (wr_en && wr_stop) begin
				stop_ok <= wd[7:0] & `CSR_CHOICE_CONN;
			end
			// allocation lives elsewhere; software mirrors its outcome here
			if (wr_en && wr_exist) begin
				exist         <= wd[7:0] & `CSR_CHOICE_CONN;
				estab         <= wd[15:8] & wd[7:0] & `CSR_CHOICE_CONN;
				set_allocated <= |(wd[7:0] & `CSR_CHOICE_CONN);
			end
			// a release in the same cycle wins over a software mirror write
			if (commit) begin
				exist         <= rel_ex;
				estab         <= rel_est & rel_ex;
				set_allocated <= rel_ex != `CSR_CHOICE_NONE;
			end
			if (state == CSR_EVAL) begin
				last_gen <= next_gen;
				last_add <= next_add;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read channel

	wire        rd_page  = s_axi_araddr[4];
	wire [3:0]  rd_word  = s_axi_araddr[3:0];
	wire [31:0] rd_lo    = rd_word == `CSR_OFF_CTRL    ? {30'h0, ctrl} :
	                       rd_word == `CSR_OFF_SUPPORT ? {24'h0, support} :
	                       rd_word == `CSR_OFF_STOPOK  ? {24'h0, stop_ok} :
	                       {16'h0, estab, exist};
	wire        rd_hi_ok = rd_word == `CSR_OFF_ESTAB || rd_word == `CSR_OFF_STATUS;
	wire [31:0] rd_hi    = rd_word == `CSR_OFF_ESTAB ? {23'h0, set_allocated, exist} :
	                       {8'h0, last_add, last_gen, 6'h0, state};
	wire        rd_ok    = rd_page == `CSR_PAGE_LO || rd_hi_ok;
	wire [31:0] rd_val   = rd_page == `CSR_PAGE_LO ? rd_lo : (rd_hi_ok ? rd_hi : 32'h0);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= `CSR_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_val;
				s_axi_rresp   <= rd_ok ? `CSR_RESP_OKAY : `CSR_RESP_SLVERR;
				s_axi_arready <= 1'b0;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			alloc_choice <= `CSR_RST_MASK;
		end else begin
			alloc_choice <= commit ? rel_ex : exist;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_zero_choice;
		state == CSR_EVAL && is_rel && has_set && !e_obj && sel == `CSR_CHOICE_NONE
		|=> rsp.err && rsp.gen == `CSR_GEN_BADVAL && rsp.add == `CSR_ADD_CHOICE;
	endproperty
	a_zero_choice: assert property (p_zero_choice) else $error("zero choice not 09/02");

	property p_no_set;
		state == CSR_EVAL && !has_set |=> rsp_valid && rsp.gen == `CSR_GEN_NOSVC;
	endproperty
	a_no_set: assert property (p_no_set) else $error("missing set not answered 08");

	property p_atomic;
		state == CSR_EVAL && any_err && !wr_en |=> $stable(exist) && $stable(estab);
	endproperty
	a_atomic: assert property (p_atomic) else $error("error changed connection state");

	property p_success;
		state == CSR_EVAL && !any_err
		|=> rsp_valid && !rsp.err && rsp.rr && rsp.service == `CSR_SVC_RELEASE;
	endproperty
	a_success: assert property (p_success) else $error("bad success response");

	property p_released;
		commit |=> (exist & $past(sel)) == `CSR_CHOICE_NONE;
	endproperty
	a_released: assert property (p_released) else $error("selected connection kept");

	property p_collapse;
		commit && collapse |=> exist == `CSR_CHOICE_NONE && !set_allocated;
	endproperty
	a_collapse: assert property (p_collapse) else $error("set not collapsed");

	property p_reserved;
		state == CSR_EVAL && is_rel && has_set && !e_obj && e_rsvd
		|=> rsp.err && rsp.gen == `CSR_GEN_BADVAL;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits accepted");

	property p_unsup;
		state == CSR_EVAL && is_rel && has_set && !e_obj && !e_rsvd && !e_zero && e_unsup
		|=> rsp.gen == `CSR_GEN_RESOURCE && rsp.add == `CSR_ADD_CHOICE;
	endproperty
	a_unsup: assert property (p_unsup) else $error("unsupported not 02/02");

	property p_answer_time;
		take_req |=> state == CSR_EVAL ##1 rsp_valid;
	endproperty
	a_answer_time: assert property (p_answer_time) else $error("answer not two cycles after take");

	property p_rsp_hold;
		rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp);
	endproperty
	a_rsp_hold: assert property (p_rsp_hold) else $error("response dropped before taken");

	c_success: cover property (commit);
	c_collapse: cover property (commit && collapse);
	c_nonexist: cover property (state == CSR_EVAL && err_gen == `CSR_GEN_STATE);
	c_nostop: cover property (state == CSR_EVAL && err_gen == `CSR_GEN_NOSTOP);

endmodule : csr_release_server

`default_nettype wire
